// >>> include/ldo_wakeup_pkg.sv
// Package for the regulator, wake-up pin and clock output control bank.
// Assumes a 32-bit APB slave whose register word addresses are four times the register index.
package ldo_wakeup_pkg;

  localparam int ADDR_W = 18;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [15:0] RTC_PM_IDX   = 16'h1930;
  localparam logic [15:0] SLEW_IDX     = 16'h1C16;
  localparam logic [15:0] REG_CTRL_IDX = 16'h7004;

  // Select lines carried between the bus port and the register core.
  localparam int SEL_RTC  = 0;
  localparam int SEL_SLEW = 1;
  localparam int SEL_REG  = 2;

  // Field positions.
  localparam int CLK_OUT_EN_BIT    = 0;
  localparam int REG_PD_BIT        = 1;
  localparam int FULL_PD_BIT       = 2;
  localparam int WAKE_DIR_BIT      = 3;
  localparam int WAKE_OUT_BIT      = 4;
  localparam int SLEW_FAST_BIT     = 2;
  localparam int USB_EN_BIT        = 0;

  // Values after reset.
  localparam logic RST_CLK_EN    = 1'b0;
  localparam logic RST_REG_PD    = 1'b0;
  localparam logic RST_FULL_PD   = 1'b0;
  localparam logic RST_WAKE_DIR  = 1'b0;
  localparam logic RST_WAKE_OUT  = 1'b1;
  localparam logic RST_SLEW_FAST = 1'b1;
  localparam logic RST_USB_EN    = 1'b0;

  // Power state of the regulators, bandgap and analog power-on reset.
  typedef enum logic [2:0] {
    PWR_ON       = 3'b001,
    PWR_REG_OFF  = 3'b010,
    PWR_FULL_OFF = 3'b100
  } power_state_t;

endpackage

// >>> include/reg_access_if.sv
// Carrier between the APB port and the register core of the power control bank.
// Assumes both ends run on the same clock.
interface reg_access_if;
  logic        wrEn;
  logic [2:0]  wrSel;
  logic [15:0] wrData;
  logic [15:0] rtcValue;
  logic [15:0] slewValue;
  logic [15:0] ldoValue;

  modport port (
    output wrEn,
    output wrSel,
    output wrData,
    input  rtcValue,
    input  slewValue,
    input  ldoValue
  );

  modport core (
    input  wrEn,
    input  wrSel,
    input  wrData,
    output rtcValue,
    output slewValue,
    output ldoValue
  );
endinterface

// >>> rtl/ldo_apb_port.sv
// APB slave port of the power control bank: decode, one wait state, read data and error answer.
// Assumes an APB master that holds the request until pready is seen high.
module ldo_apb_port (
  input  wire logic                             sys_clk,
  input  wire logic                             reset_n,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [ldo_wakeup_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  reg_access_if.port                            acc
);

  function automatic logic hit(input logic [ldo_wakeup_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  wire  [2:0]  sel;
  wire         mapped;
  wire         done;
  wire  [15:0] readValue;

  assign sel[ldo_wakeup_pkg::SEL_RTC]  = hit(paddr, ldo_wakeup_pkg::RTC_PM_IDX);
  assign sel[ldo_wakeup_pkg::SEL_SLEW] = hit(paddr, ldo_wakeup_pkg::SLEW_IDX);
  assign sel[ldo_wakeup_pkg::SEL_REG]  = hit(paddr, ldo_wakeup_pkg::REG_CTRL_IDX);
  assign mapped    = |sel;
  // The answer comes in the second access cycle, so the completing edge is where pready_r is high.
  assign done      = psel && penable && pready_r;
  assign readValue = sel[ldo_wakeup_pkg::SEL_RTC]  ? acc.rtcValue :
                     sel[ldo_wakeup_pkg::SEL_SLEW] ? acc.slewValue :
                     sel[ldo_wakeup_pkg::SEL_REG]  ? acc.ldoValue : 16'h0000;

  // All fields sit in byte lane 0, so only that strobe lets a write through.
  assign acc.wrEn   = done && pwrite && mapped && pstrb[0];
  assign acc.wrSel  = sel;
  assign acc.wrData = pwdata[15:0];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      prdata_r  <= (psel && penable && !pready_r && !pwrite) ? {16'h0000, readValue} : 32'h0000_0000;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

endmodule

// >>> rtl/ldo_wakeup_power_control.sv
// Power and pin control bank: wake-up pin, regulator and bandgap power-down, clock output control.
// Assumes an APB master on sys_clk and pad, alarm and wake inputs already synchronous to sys_clk.
//
// Overview of operation
// - Wake output bit 0 drives the wake pin low; 1 leaves it floating.
// - Wake direction bit 0 makes the pin an input, 1 an output.
// - As input the pin is active high; as output active-low open-drain.
// - Pin wake-up works only while the direction bit selects input.
// - Full power-down bit shuts regulators, power-on reset and bandgap.
// - Regulator power-down bit shuts regulators and power-on reset, keeps bandgap.
// - A high wake pin or an RTC alarm re-enables shut-down circuits.
// - Clock output enable bit 0 disables, 1 enables the clock output.
// - Bits 15 to 5 of the RTC power register read zero, ignore writes.
// - Bits 15 to 1 of the regulator control register read zero, ignore writes.
// - USB regulator enable bit 1 turns output on; 0 floats its pin.
// - Analog regulator on when no power-down; USB also needs its enable.
// - Slew select bit 2: 0 slow, 1 fast, resets to fast.
// - USB regulator enable resets to 0.
module ldo_wakeup_power_control (
  input  wire logic                             sys_clk,
  input  wire logic                             reset_n,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [ldo_wakeup_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             wakePinIn,
  output logic                                  wakePinOut,
  output logic                                  wakePinOe,
  output logic                                  wakeIdleRequest,
  input  wire logic                             rtcAlarm,
  output logic                                  analogRegulatorOn,
  output logic                                  usbRegulatorOn,
  output logic                                  usbRegulatorOutputPinOe,
  output logic                                  analogPorOn,
  output logic                                  bandgapOn,
  output logic                                  rtcClockOutputEnable,
  output logic                                  clockOutputSlewFast
);

  reg_access_if acc ();

  ldo_apb_port u_apb (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .acc     (acc.port)
  );

  // Stored register fields.
  logic wakeOutLevel_r;
  logic wakeDir_r;
  logic fullPd_r;
  logic regPd_r;
  logic clkOutEn_r;
  logic slewFast_r;
  logic usbEn_r;

  logic wakeOutLevel_nxt;
  logic wakeDir_nxt;
  logic fullPd_nxt;
  logic regPd_nxt;
  logic clkOutEn_nxt;
  logic slewFast_nxt;
  logic usbEn_nxt;

  ldo_wakeup_pkg::power_state_t state_r;
  ldo_wakeup_pkg::power_state_t state_nxt;

  // Output flops.
  logic wakePinOe_r;
  logic wakeIdleRequest_r;
  logic analogOn_r;
  logic usbOn_r;
  logic porOn_r;
  logic bandgapOn_r;
  logic clkOutOut_r;
  logic slewOut_r;

  wire wrRtc;
  wire wrSlew;
  wire wrLdo;
  wire pinWakeLevel;
  wire wakeEvent;
  wire poweredDown;

  assign wrRtc  = acc.wrEn && acc.wrSel[ldo_wakeup_pkg::SEL_RTC];
  assign wrSlew = acc.wrEn && acc.wrSel[ldo_wakeup_pkg::SEL_SLEW];
  assign wrLdo  = acc.wrEn && acc.wrSel[ldo_wakeup_pkg::SEL_REG];

  // The pin counts as a wake source only while it is an input, and then it is active high.
  assign pinWakeLevel = !wakeDir_r && wakePinIn;
  assign poweredDown  = (state_r != ldo_wakeup_pkg::PWR_ON);
  assign wakeEvent    = poweredDown && (pinWakeLevel || rtcAlarm);

  // Register field updates; reserved bits are simply not stored.
  always_comb begin
    wakeOutLevel_nxt = wakeOutLevel_r;
    wakeDir_nxt      = wakeDir_r;
    fullPd_nxt       = fullPd_r;
    regPd_nxt        = regPd_r;
    clkOutEn_nxt     = clkOutEn_r;
    slewFast_nxt     = slewFast_r;
    usbEn_nxt        = usbEn_r;
    if (wrRtc) begin
      wakeOutLevel_nxt = acc.wrData[ldo_wakeup_pkg::WAKE_OUT_BIT];
      wakeDir_nxt      = acc.wrData[ldo_wakeup_pkg::WAKE_DIR_BIT];
      fullPd_nxt       = acc.wrData[ldo_wakeup_pkg::FULL_PD_BIT];
      regPd_nxt        = acc.wrData[ldo_wakeup_pkg::REG_PD_BIT];
      clkOutEn_nxt     = acc.wrData[ldo_wakeup_pkg::CLK_OUT_EN_BIT];
    end
    if (wrSlew) begin
      slewFast_nxt = acc.wrData[ldo_wakeup_pkg::SLEW_FAST_BIT];
    end
    if (wrLdo) begin
      usbEn_nxt = acc.wrData[ldo_wakeup_pkg::USB_EN_BIT];
    end
    // Hardware re-enable clears both power-down bits so software sees the circuits are back on.
    // A wake in the same cycle as a power-down write wins only while already powered down; in PWR_ON the write takes effect.
    if (wakeEvent) begin
      fullPd_nxt = 1'b0;
      regPd_nxt  = 1'b0;
    end
  end

  // Power state follows the power-down bits; full power-down outranks regulator power-down.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ldo_wakeup_pkg::PWR_ON: begin
        if (fullPd_nxt) begin
          state_nxt = ldo_wakeup_pkg::PWR_FULL_OFF;
        end else if (regPd_nxt) begin
          state_nxt = ldo_wakeup_pkg::PWR_REG_OFF;
        end
      end
      ldo_wakeup_pkg::PWR_REG_OFF: begin
        if (wakeEvent) begin
          state_nxt = ldo_wakeup_pkg::PWR_ON;
        end else if (fullPd_nxt) begin
          state_nxt = ldo_wakeup_pkg::PWR_FULL_OFF;
        end else if (!regPd_nxt) begin
          state_nxt = ldo_wakeup_pkg::PWR_ON;
        end
      end
      ldo_wakeup_pkg::PWR_FULL_OFF: begin
        if (wakeEvent) begin
          state_nxt = ldo_wakeup_pkg::PWR_ON;
        end else if (!fullPd_nxt) begin
          state_nxt = regPd_nxt ? ldo_wakeup_pkg::PWR_REG_OFF : ldo_wakeup_pkg::PWR_ON;
        end
      end
      default: begin
        state_nxt = ldo_wakeup_pkg::PWR_ON;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeOutLevel_r <= ldo_wakeup_pkg::RST_WAKE_OUT;
      wakeDir_r      <= ldo_wakeup_pkg::RST_WAKE_DIR;
      fullPd_r       <= ldo_wakeup_pkg::RST_FULL_PD;
      regPd_r        <= ldo_wakeup_pkg::RST_REG_PD;
      clkOutEn_r     <= ldo_wakeup_pkg::RST_CLK_EN;
      slewFast_r     <= ldo_wakeup_pkg::RST_SLEW_FAST;
      usbEn_r        <= ldo_wakeup_pkg::RST_USB_EN;
      state_r        <= ldo_wakeup_pkg::PWR_ON;
    end else begin
      wakeOutLevel_r <= wakeOutLevel_nxt;
      wakeDir_r      <= wakeDir_nxt;
      fullPd_r       <= fullPd_nxt;
      regPd_r        <= regPd_nxt;
      clkOutEn_r     <= clkOutEn_nxt;
      slewFast_r     <= slewFast_nxt;
      usbEn_r        <= usbEn_nxt;
      state_r        <= state_nxt;
    end
  end

  // Outputs except wakeIdleRequest_r are computed from the next values so they change at the edge that completes a write.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakePinOe_r       <= 1'b0;
      wakeIdleRequest_r <= 1'b0;
      analogOn_r        <= 1'b1;
      usbOn_r           <= 1'b0;
      porOn_r           <= 1'b1;
      bandgapOn_r       <= 1'b1;
      clkOutOut_r       <= ldo_wakeup_pkg::RST_CLK_EN;
      slewOut_r         <= ldo_wakeup_pkg::RST_SLEW_FAST;
    end else begin
      wakePinOe_r       <= wakeDir_nxt && !wakeOutLevel_nxt;
      wakeIdleRequest_r <= !wakeDir_r && wakePinIn;
      analogOn_r        <= (state_nxt == ldo_wakeup_pkg::PWR_ON);
      usbOn_r           <= (state_nxt == ldo_wakeup_pkg::PWR_ON) && usbEn_nxt;
      porOn_r           <= (state_nxt == ldo_wakeup_pkg::PWR_ON);
      bandgapOn_r       <= (state_nxt != ldo_wakeup_pkg::PWR_FULL_OFF);
      clkOutOut_r       <= clkOutEn_nxt;
      slewOut_r         <= slewFast_nxt;
    end
  end

  // The wake pin is open-drain: its output level is always low and only the enable moves.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakePinOut <= 1'b0;
    end else begin
      wakePinOut <= 1'b0;
    end
  end

  // Read-back values; reserved bits read as zero.
  assign acc.rtcValue  = {11'h000, wakeOutLevel_r, wakeDir_r, fullPd_r, regPd_r, clkOutEn_r};
  assign acc.slewValue = {13'h0000, slewFast_r, 2'h0};
  assign acc.ldoValue  = {15'h0000, usbEn_r};

  assign wakePinOe               = wakePinOe_r;
  assign wakeIdleRequest         = wakeIdleRequest_r;
  assign analogRegulatorOn       = analogOn_r;
  assign usbRegulatorOn          = usbOn_r;
  assign usbRegulatorOutputPinOe = usbOn_r;
  assign analogPorOn             = porOn_r;
  assign bandgapOn               = bandgapOn_r;
  assign rtcClockOutputEnable    = clkOutOut_r;
  assign clockOutputSlewFast     = slewOut_r;

endmodule

// >>> verif/ldo_wakeup_checker.sv
// Concurrent checks on the pins of the power control bank.
// Assumes an APB master that holds each request until pready, and synchronous wake inputs.
module ldo_wakeup_checker (
  input wire logic                              sys_clk,
  input wire logic                              reset_n,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [ldo_wakeup_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                       pwdata,
  input wire logic [3:0]                        pstrb,
  input wire logic [31:0]                       prdata,
  input wire logic                              pready,
  input wire logic                              wakePinIn,
  input wire logic                              wakePinOe,
  input wire logic                              wakeIdleRequest,
  input wire logic                              rtcAlarm,
  input wire logic                              analogRegulatorOn,
  input wire logic                              usbRegulatorOn,
  input wire logic                              usbRegulatorOutputPinOe,
  input wire logic                              analogPorOn,
  input wire logic                              bandgapOn,
  input wire logic                              clockOutputSlewFast
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire done   = psel & penable & pready;
  wire wrRtc  = done & pwrite & pstrb[0] & (paddr == 18'h064C0);
  wire wrSlew = done & pwrite & pstrb[0] & (paddr == 18'h07058);
  wire rdDone = done & !pwrite;
  // A wake in the same cycle as a power-down write cancels it once powered down, so those cycles are left out.
  wire noWake = !rtcAlarm & !wakePinIn;
  // Mirror of the direction bit taken from bus writes, so pin wake is judged independently of the pad.
  logic dirSeen;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dirSeen <= 1'b0;
    end else if (wrRtc) begin
      dirSeen <= pwdata[3];
    end
  end
  sequence setupCyc;
    psel && !penable;
  endsequence
  sequence oneWait;
    (psel && penable && !pready) ##1 pready;
  endsequence
  AST_READY: assert property (setupCyc |=> oneWait)
    else $error("pready not in second access cycle");
  AST_WAKE_OE: assert property (wrRtc |=> wakePinOe == ($past(pwdata[3]) && !$past(pwdata[4])))
    else $error("wake pin drive differs from written bits");
  AST_IDLE: assert property ($past(dirSeen) |-> !wakeIdleRequest)
    else $error("pin wake seen while pin is an output");
  AST_FULL_PD: assert property (wrRtc && pwdata[2] && noWake
    |=> !bandgapOn && !analogRegulatorOn && !analogPorOn && !usbRegulatorOn)
    else $error("full power-down left a circuit on");
  AST_REG_PD: assert property (wrRtc && pwdata[1] && !pwdata[2] && noWake
    |=> bandgapOn && !analogRegulatorOn && !analogPorOn)
    else $error("regulator power-down wrong");
  AST_WAKE_ON: assert property (!analogRegulatorOn && rtcAlarm |=> analogRegulatorOn && analogPorOn && bandgapOn)
    else $error("alarm did not re-enable circuits");
  AST_USB: assert property ((usbRegulatorOutputPinOe == usbRegulatorOn)
    && (analogRegulatorOn || !usbRegulatorOn))
    else $error("usb regulator state inconsistent");
  AST_SLEW: assert property (wrSlew |=> clockOutputSlewFast == $past(pwdata[2]))
    else $error("slew output differs from written bit");
  AST_RSVD: assert property (rdDone |-> prdata[31:16] == 16'h0000
    && (paddr != 18'h064C0 || prdata[15:5] == 11'h000)
    && (paddr != 18'h1C010 || prdata[15:1] == 15'h0000))
    else $error("reserved bits read nonzero");
endmodule

bind ldo_wakeup_power_control ldo_wakeup_checker i_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .wakePinIn(wakePinIn), .wakePinOe(wakePinOe), .wakeIdleRequest(wakeIdleRequest), .rtcAlarm(rtcAlarm),
  .analogRegulatorOn(analogRegulatorOn), .usbRegulatorOn(usbRegulatorOn), .analogPorOn(analogPorOn),
  .usbRegulatorOutputPinOe(usbRegulatorOutputPinOe), .bandgapOn(bandgapOn), .clockOutputSlewFast(clockOutputSlewFast)
);

// >>> verif/wake_pad_model.sv
// Pad model of the wake-up pin: the device's open-drain pull-down against an external source.
// Assumes the external source drives the pin whenever the device does not pull it.
module wake_pad_model (
  input  wire logic wakePinOut,
  input  wire logic wakePinOe,
  input  wire logic extLevel,
  output logic      wakePinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // The device pulling low wins, as on a real open-drain wire.
  assign wakePinIn = wakePinOe ? wakePinOut : extLevel;
endmodule

// >>> verif/ldo_wakeup_power_control_tb_top.sv
// Testbench of the power control bank: APB register tasks and pin checks.
// Assumes the pad model on the wake pin and the bound checker.
module ldo_wakeup_power_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [17:0] A_RTC = 18'h064C0;
  localparam logic [17:0] A_SLW = 18'h07058;
  localparam logic [17:0] A_REG = 18'h1C010;
  logic        sys_clk = 1'b0;
  logic        reset_n, psel, penable, pwrite, extLevel, rtcAlarm, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic        pready, pslverr, wakePinIn, wakePinOut, wakePinOe, wakeIdleRequest;
  logic        analogRegulatorOn, usbRegulatorOn, usbRegulatorOutputPinOe, analogPorOn, bandgapOn;
  logic        rtcClockOutputEnable, clockOutputSlewFast;
  int          n_fail, n_compared;
  wire logic [3:0] pwr = {bandgapOn, analogRegulatorOn, analogPorOn, usbRegulatorOn};

  always #5 sys_clk = ~sys_clk;

  ldo_wakeup_power_control i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakePinIn(wakePinIn), .wakePinOut(wakePinOut), .wakePinOe(wakePinOe), .wakeIdleRequest(wakeIdleRequest),
    .rtcAlarm(rtcAlarm), .analogRegulatorOn(analogRegulatorOn), .usbRegulatorOn(usbRegulatorOn),
    .usbRegulatorOutputPinOe(usbRegulatorOutputPinOe), .analogPorOn(analogPorOn), .bandgapOn(bandgapOn),
    .rtcClockOutputEnable(rtcClockOutputEnable), .clockOutputSlewFast(clockOutputSlewFast)
  );
  wake_pad_model i_pad (.wakePinOut(wakePinOut), .wakePinOe(wakePinOe), .extLevel(extLevel), .wakePinIn(wakePinIn));

  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      close_out();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs written at the completing edge are looked at once they have landed.
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rdv, exp);
  endtask

  task automatic wake(input logic byPin);
    @(posedge sys_clk);
    extLevel <= byPin;
    rtcAlarm <= !byPin;
    @(posedge sys_clk);
    extLevel <= 1'b0;
    rtcAlarm <= 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    {reset_n, psel, penable, pwrite, extLevel, rtcAlarm} = 6'h00;
    paddr = 18'h00000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk({pwr, clockOutputSlewFast}, 5'h1D);
    rd(A_RTC, 32'h0000_0010);
    rd(A_SLW, 32'h0000_0004);
    rd(A_REG, 32'h0000_0000);
    xfer(1'b1, A_RTC, 32'hFFFF_FFE9, 4'hF);
    rd(A_RTC, 32'h0000_0009);
    chk({wakePinOe, wakePinOut, rtcClockOutputEnable}, 3'b101);
    xfer(1'b1, A_RTC, 32'h0000_0018, 4'hF);
    chk({wakePinOe, rtcClockOutputEnable}, 2'b00);
    @(posedge sys_clk);
    extLevel <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(wakeIdleRequest, 1'b0);
    // Internal regulators are taken to be in use throughout, so the power-down bits are legal.
    xfer(1'b1, A_RTC, 32'h0000_001C, 4'hF);
    chk(pwr, 4'h0);
    wake(1'b0);
    chk(pwr, 4'hE);
    rd(A_RTC, 32'h0000_0018);
    xfer(1'b1, A_RTC, 32'h0000_0010, 4'hF);
    @(posedge sys_clk);
    extLevel <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(wakeIdleRequest, 1'b1);
    @(posedge sys_clk);
    extLevel <= 1'b0;
    xfer(1'b1, A_REG, 32'hFFFF_FFFF, 4'hF);
    rd(A_REG, 32'h0000_0001);
    chk({pwr, usbRegulatorOutputPinOe}, 5'h1F);
    xfer(1'b1, A_RTC, 32'h0000_0014, 4'hF);
    chk({pwr, usbRegulatorOutputPinOe}, 5'h00);
    rd(A_RTC, 32'h0000_0014);
    wake(1'b1);
    chk(pwr, 4'hF);
    xfer(1'b1, A_RTC, 32'h0000_0012, 4'hF);
    chk(pwr, 4'h8);
    wake(1'b0);
    chk(pwr, 4'hF);
    xfer(1'b1, A_REG, 32'h0000_0000, 4'hF);
    chk({pwr, usbRegulatorOutputPinOe}, 5'h1C);
    xfer(1'b1, A_SLW, 32'h0000_0000, 4'hF);
    rd(A_SLW, 32'h0000_0000);
    chk(clockOutputSlewFast, 1'b0);
    xfer(1'b1, A_SLW, 32'hFFFF_FFFF, 4'hF);
    rd(A_SLW, 32'h0000_0004);
    chk(clockOutputSlewFast, 1'b1);
    xfer(1'b1, A_SLW, 32'h0000_0000, 4'h0);
    rd(A_SLW, 32'h0000_0004);
    xfer(1'b0, 18'h00100, 32'h0000_0000, 4'hF);
    chk(err, 1'b1);
    chk(rdv, 32'h0000_0000);
    // Every field except the two power-down bits is moved off its reset value first, so that the second reset is visible.
    xfer(1'b1, A_RTC, 32'h0000_0009, 4'hF);
    xfer(1'b1, A_SLW, 32'h0000_0000, 4'hF);
    xfer(1'b1, A_REG, 32'h0000_0001, 4'hF);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk({pwr, clockOutputSlewFast, wakePinOe, rtcClockOutputEnable}, 7'h74);
    rd(A_RTC, 32'h0000_0010);
    rd(A_SLW, 32'h0000_0004);
    rd(A_REG, 32'h0000_0000);
    close_out();
  end
endmodule
